/* rtl/source_measure_event_status.sv */
// Source and measure condition/event status logic for two channels
//
// Contract
// [RQ1] Condition rising edge latches event bit
// [RQ2] Sweep start during sweep pulses bit 15
// [RQ3] Source bit 14 follows interlock
// [RQ4] Emergency on source bits 13 and 5
// [RQ5] Trip sets event bits 12, 4 directly
// [RQ6] Upper limiter on source bits 11, 3
// [RQ7] Lower limiter on source bits 10, 2
// [RQ8] Ready bits 9, 1 low while sweeping
// [RQ9] Sweep done on source bits 8, 0
// [RQ10] Unused source and measure bits read zero
// [RQ11] Source enable masks events from summary
// [RQ12] Source event read returns then clears
// [RQ13] Condition reads have no side effects
// [RQ14] Source events cleared by read, clear, reset
// [RQ15] Trigger during activity pulses measure bit 15
// [RQ16] Measure bit 14 high when storage idle
// [RQ17] Over range on measure bits 13, 5
// [RQ18] Compare above on measure bits 11, 3
// [RQ19] Compare below on measure bits 10, 2
// [RQ20] Measure idle bits 8, 0
// [RQ21] Measure enable masks events from summary
// [RQ22] Measure event read returns then clears
// [RQ23] Measure summary is status byte bit 0
// [RQ24] Source summary is any enabled event
// [RQ25] Measure events cleared by read, clear, reset
// [RQ26] Single-cycle error pulses still latch
// [RQ27] Edge during clearing read is kept
`timescale 1ns/10ps
`default_nettype none

module source_measure_event_status
    import smu_status_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    // Channel one source side
    input wire logic ch1_sweep_start,
    input wire logic ch1_sweep_running,
    input wire logic ch1_emergency,
    input wire logic ch1_output_tripped,
    input wire logic ch1_upper_limiting,
    input wire logic ch1_lower_limiting,
    // Channel two source side and the shared interlock
    input wire logic ch2_sweep_start,
    input wire logic ch2_sweep_running,
    input wire logic ch2_emergency,
    input wire logic ch2_output_tripped,
    input wire logic ch2_upper_limiting,
    input wire logic ch2_lower_limiting,
    input wire logic interlock_active,
    // Measure side
    input wire logic measure_trigger,
    input wire logic storage_busy,
    input wire logic ch1_measuring,
    input wire logic ch1_over_range,
    input wire logic ch1_compare_above,
    input wire logic ch1_compare_below,
    input wire logic ch2_measuring,
    input wire logic ch2_over_range,
    input wire logic ch2_compare_above,
    input wire logic ch2_compare_below,
    // Command port from the command interpreter
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [REG_W-1:0] cmd_wdata,
    output logic cmd_ready_ff,
    output logic rsp_valid_ff,
    output logic [REG_W-1:0] rsp_data_ff,
    // Status byte summary bits and the measure enable register
    output logic source_summary_ff,
    output logic measure_summary_ff,
    output logic [REG_W-1:0] measure_enable_ff
);

    state_t state_ff;
    state_t nxt_state;
    logic [REG_W-1:0] source_enable_ff;
    logic [REG_W-1:0] nxt_source_enable;
    logic [REG_W-1:0] nxt_measure_enable;
    logic [REG_W-1:0] nxt_rsp_data;
    logic nxt_rsp_valid;
    logic nxt_cmd_ready;
    logic nxt_source_summary;
    logic nxt_measure_summary;

    logic ch1_running_prev_ff;
    logic ch2_running_prev_ff;
    logic ch1_sweep_done_ff;
    logic ch2_sweep_done_ff;
    logic nxt_ch1_sweep_done;
    logic nxt_ch2_sweep_done;

    logic [REG_W-1:0] src_cond_in;
    logic [REG_W-1:0] src_direct;
    logic [REG_W-1:0] mea_cond_in;
    logic [REG_W-1:0] source_condition;
    logic [REG_W-1:0] source_event_latch;
    logic [REG_W-1:0] measure_condition;
    logic [REG_W-1:0] measure_event_latch;

    logic cmd_take;
    cmd_t cmd;
    logic clear_status;
    logic src_event_clear;
    logic mea_event_clear;
    logic sweep_start_overlap_error;
    logic trigger_overlap_error;
    logic storage_idle;
    logic ch1_measure_idle;
    logic ch2_measure_idle;
    logic ch1_sweep_ready;
    logic ch2_sweep_ready;
    logic ch1_sweep_finished;
    logic ch2_sweep_finished;

    function automatic logic any_enabled(input logic [REG_W-1:0] events,
                                         input logic [REG_W-1:0] enables);
        any_enabled = |(events & enables);
    endfunction

    function automatic logic sweep_done_next(input logic done, input logic start,
                                             input logic finished);
        // A finish in the same cycle as a new start leaves done set
        sweep_done_next = finished | (done & ~start);
    endfunction

    // Command decode
    assign cmd = cmd_t'(cmd_code);
    assign cmd_take = cmd_valid && (state_ff == ST_IDLE);
    assign clear_status = cmd_take && (cmd == CMD_CLEAR_STATUS);
    assign src_event_clear = clear_status || (cmd_take && cmd == CMD_READ_SRC_EVENT); // [RQ14]
    assign mea_event_clear = clear_status || (cmd_take && cmd == CMD_READ_MEA_EVENT); // [RQ25]

    // Derived source conditions
    assign sweep_start_overlap_error = (ch1_sweep_start & ch1_sweep_running) |
                                       (ch2_sweep_start & ch2_sweep_running); // [RQ2]
    assign ch1_sweep_ready = ~ch1_sweep_running; // [RQ8]
    assign ch2_sweep_ready = ~ch2_sweep_running; // [RQ8]
    assign ch1_sweep_finished = ch1_running_prev_ff & ~ch1_sweep_running;
    assign ch2_sweep_finished = ch2_running_prev_ff & ~ch2_sweep_running;
    assign nxt_ch1_sweep_done = sweep_done_next(ch1_sweep_done_ff, ch1_sweep_start,
                                                ch1_sweep_finished);
    assign nxt_ch2_sweep_done = sweep_done_next(ch2_sweep_done_ff, ch2_sweep_start,
                                                ch2_sweep_finished);

    // Derived measure conditions
    assign trigger_overlap_error = measure_trigger &
        (ch1_sweep_running | ch2_sweep_running | ch1_measuring | ch2_measuring); // [RQ15]
    assign storage_idle = ~storage_busy; // [RQ16]
    assign ch1_measure_idle = ~ch1_measuring; // [RQ20]
    assign ch2_measure_idle = ~ch2_measuring; // [RQ20]

    // Source condition word
    always_comb begin
        src_cond_in = COND_RESET;
        src_cond_in[SRC_OVERLAP_BIT] = sweep_start_overlap_error; // [RQ2]
        src_cond_in[SRC_INTERLOCK_BIT] = interlock_active; // [RQ3]
        src_cond_in[SRC_CH2_EMERG_BIT] = ch2_emergency; // [RQ4]
        src_cond_in[SRC_CH1_EMERG_BIT] = ch1_emergency; // [RQ4]
        src_cond_in[SRC_CH2_UPPER_BIT] = ch2_upper_limiting; // [RQ6]
        src_cond_in[SRC_CH1_UPPER_BIT] = ch1_upper_limiting; // [RQ6]
        src_cond_in[SRC_CH2_LOWER_BIT] = ch2_lower_limiting; // [RQ7]
        src_cond_in[SRC_CH1_LOWER_BIT] = ch1_lower_limiting; // [RQ7]
        src_cond_in[SRC_CH2_READY_BIT] = ch2_sweep_ready; // [RQ8]
        src_cond_in[SRC_CH1_READY_BIT] = ch1_sweep_ready; // [RQ8]
        src_cond_in[SRC_CH2_DONE_BIT] = ch2_sweep_done_ff; // [RQ9]
        src_cond_in[SRC_CH1_DONE_BIT] = ch1_sweep_done_ff; // [RQ9]
    end

    // Trip bits have no condition; they go straight to the event word
    always_comb begin
        src_direct = EVENT_RESET;
        src_direct[SRC_CH2_TRIP_BIT] = ch2_output_tripped; // [RQ5]
        src_direct[SRC_CH1_TRIP_BIT] = ch1_output_tripped; // [RQ5]
    end

    // Measure condition word
    always_comb begin
        mea_cond_in = COND_RESET;
        mea_cond_in[MEA_TRIGGER_BIT] = trigger_overlap_error; // [RQ15]
        mea_cond_in[MEA_STORAGE_BIT] = storage_idle; // [RQ16]
        mea_cond_in[MEA_CH2_OVR_BIT] = ch2_over_range; // [RQ17]
        mea_cond_in[MEA_CH1_OVR_BIT] = ch1_over_range; // [RQ17]
        mea_cond_in[MEA_CH2_ABOVE_BIT] = ch2_compare_above; // [RQ18]
        mea_cond_in[MEA_CH1_ABOVE_BIT] = ch1_compare_above; // [RQ18]
        mea_cond_in[MEA_CH2_BELOW_BIT] = ch2_compare_below; // [RQ19]
        mea_cond_in[MEA_CH1_BELOW_BIT] = ch1_compare_below; // [RQ19]
        mea_cond_in[MEA_CH2_IDLE_BIT] = ch2_measure_idle; // [RQ20]
        mea_cond_in[MEA_CH1_IDLE_BIT] = ch1_measure_idle; // [RQ20]
    end

    edge_event_latch #(
        .COND_MASK(SRC_COND_MASK),
        .EVENT_MASK(SRC_EVENT_MASK)
    ) source_latch (
        .clock(clock),
        .rst_n(rst_n),
        .cond_in(src_cond_in),
        .direct_set(src_direct),
        .clear(src_event_clear),
        .cond_ff(source_condition),
        .event_ff(source_event_latch)
    );

    edge_event_latch #(
        .COND_MASK(MEA_MASK),
        .EVENT_MASK(MEA_MASK)
    ) measure_latch (
        .clock(clock),
        .rst_n(rst_n),
        .cond_in(mea_cond_in),
        .direct_set(EVENT_RESET),
        .clear(mea_event_clear),
        .cond_ff(measure_condition),
        .event_ff(measure_event_latch)
    );

    // Enable registers are software state; clear-status leaves them alone
    assign nxt_source_enable = (cmd_take && cmd == CMD_WRITE_SRC_ENABLE) ?
                               (cmd_wdata & SRC_EVENT_MASK) : source_enable_ff;
    assign nxt_measure_enable = (cmd_take && cmd == CMD_WRITE_MEA_ENABLE) ?
                                (cmd_wdata & MEA_MASK) : measure_enable_ff;

    // Summaries use the event words of this cycle, one cycle late at the pins
    assign nxt_source_summary = any_enabled(source_event_latch, source_enable_ff); // [RQ11] [RQ24]
    assign nxt_measure_summary = any_enabled(measure_event_latch, measure_enable_ff); // [RQ21] [RQ23]

    // Reply data: event reads sample before the clear lands on the same edge
    always_comb begin
        nxt_rsp_data = rsp_data_ff;
        if (cmd_take) begin
            unique case (cmd)
                CMD_READ_SRC_COND: nxt_rsp_data = source_condition; // [RQ13]
                CMD_READ_SRC_EVENT: nxt_rsp_data = source_event_latch; // [RQ12]
                CMD_READ_MEA_COND: nxt_rsp_data = measure_condition; // [RQ13]
                CMD_READ_MEA_EVENT: nxt_rsp_data = measure_event_latch; // [RQ22]
                CMD_READ_SRC_ENABLE: nxt_rsp_data = source_enable_ff;
                CMD_WRITE_SRC_ENABLE: nxt_rsp_data = COND_RESET;
                CMD_WRITE_MEA_ENABLE: nxt_rsp_data = COND_RESET;
                CMD_CLEAR_STATUS: nxt_rsp_data = COND_RESET;
            endcase
        end
    end

    // One command per two cycles: take, then reply
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (cmd_valid) begin
                    nxt_state = ST_REPLY;
                end
            end
            ST_REPLY: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    assign nxt_rsp_valid = cmd_take;
    assign nxt_cmd_ready = (nxt_state == ST_IDLE);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            cmd_ready_ff <= 1'b1;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= COND_RESET;
        end else begin
            state_ff <= nxt_state;
            cmd_ready_ff <= nxt_cmd_ready;
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_data_ff <= nxt_rsp_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            source_enable_ff <= ENABLE_RESET;
            measure_enable_ff <= ENABLE_RESET;
            source_summary_ff <= 1'b0;
            measure_summary_ff <= 1'b0;
        end else begin
            source_enable_ff <= nxt_source_enable;
            measure_enable_ff <= nxt_measure_enable;
            source_summary_ff <= nxt_source_summary; // [RQ24]
            measure_summary_ff <= nxt_measure_summary; // [RQ23]
        end
    end

    // Sweep completion tracking per channel
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ch1_running_prev_ff <= 1'b0;
            ch2_running_prev_ff <= 1'b0;
            ch1_sweep_done_ff <= 1'b0;
            ch2_sweep_done_ff <= 1'b0;
        end else begin
            ch1_running_prev_ff <= ch1_sweep_running;
            ch2_running_prev_ff <= ch2_sweep_running;
            ch1_sweep_done_ff <= nxt_ch1_sweep_done; // [RQ9]
            ch2_sweep_done_ff <= nxt_ch2_sweep_done; // [RQ9]
        end
    end

endmodule // source_measure_event_status

`default_nettype wire

/* rtl/smu_status_pkg.sv */
// Constants and types shared by the status event logic
package smu_status_pkg;

    localparam int REG_W = 16;

    // Source condition and event bit positions
    localparam int SRC_CH1_DONE_BIT = 0;
    localparam int SRC_CH1_READY_BIT = 1;
    localparam int SRC_CH1_LOWER_BIT = 2;
    localparam int SRC_CH1_UPPER_BIT = 3;
    localparam int SRC_CH1_TRIP_BIT = 4;
    localparam int SRC_CH1_EMERG_BIT = 5;
    localparam int SRC_CH2_DONE_BIT = 8;
    localparam int SRC_CH2_READY_BIT = 9;
    localparam int SRC_CH2_LOWER_BIT = 10;
    localparam int SRC_CH2_UPPER_BIT = 11;
    localparam int SRC_CH2_TRIP_BIT = 12;
    localparam int SRC_CH2_EMERG_BIT = 13;
    localparam int SRC_INTERLOCK_BIT = 14;
    localparam int SRC_OVERLAP_BIT = 15;

    // Measure condition and event bit positions
    localparam int MEA_CH1_IDLE_BIT = 0;
    localparam int MEA_CH1_BELOW_BIT = 2;
    localparam int MEA_CH1_ABOVE_BIT = 3;
    localparam int MEA_CH1_OVR_BIT = 5;
    localparam int MEA_CH2_IDLE_BIT = 8;
    localparam int MEA_CH2_BELOW_BIT = 10;
    localparam int MEA_CH2_ABOVE_BIT = 11;
    localparam int MEA_CH2_OVR_BIT = 13;
    localparam int MEA_STORAGE_BIT = 14;
    localparam int MEA_TRIGGER_BIT = 15;

    // Bits that exist; the rest always read zero
    localparam logic [REG_W-1:0] SRC_COND_MASK = 16'hEE2E | 16'h0101;
    localparam logic [REG_W-1:0] SRC_EVENT_MASK = 16'hFF3F;
    localparam logic [REG_W-1:0] MEA_MASK = 16'hED2D;

    // Reset values
    localparam logic [REG_W-1:0] ENABLE_RESET = 16'h0000;
    localparam logic [REG_W-1:0] EVENT_RESET = 16'h0000;
    localparam logic [REG_W-1:0] COND_RESET = 16'h0000;
    // Edge history starts high so idle/ready levels do not latch at power-up
    localparam logic [REG_W-1:0] HISTORY_RESET = 16'hFFFF;

    // Command codes from the command interpreter
    typedef enum logic [2:0] {
        CMD_READ_SRC_COND = 3'h0,
        CMD_READ_SRC_EVENT = 3'h1,
        CMD_READ_MEA_COND = 3'h2,
        CMD_READ_MEA_EVENT = 3'h3,
        CMD_WRITE_SRC_ENABLE = 3'h4,
        CMD_WRITE_MEA_ENABLE = 3'h5,
        CMD_READ_SRC_ENABLE = 3'h6,
        CMD_CLEAR_STATUS = 3'h7
    } cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_REPLY = 2'h2
    } state_t;

endpackage

/* rtl/edge_event_latch.sv */
// Condition sampling, rising edge detection and sticky event bits
`timescale 1ns/10ps
`default_nettype none

module edge_event_latch
    import smu_status_pkg::*;
#(
    parameter logic [REG_W-1:0] COND_MASK = 16'hFFFF,
    parameter logic [REG_W-1:0] EVENT_MASK = 16'hFFFF
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [REG_W-1:0] cond_in,
    input wire logic [REG_W-1:0] direct_set,
    input wire logic clear,
    output logic [REG_W-1:0] cond_ff,
    output logic [REG_W-1:0] event_ff
);

    logic [REG_W-1:0] history_ff;
    logic [REG_W-1:0] nxt_history;
    logic armed_ff;
    logic [REG_W-1:0] rise;
    logic [REG_W-1:0] nxt_event;

    // First edge after reset keeps the all-ones history, else levels
    // already high at release would look like fresh edges
    assign nxt_history = armed_ff ? cond_ff : HISTORY_RESET;

    // Condition registered every cycle so one-cycle pulses are kept
    assign rise = cond_ff & ~history_ff;
    // Set beats clear so no edge is lost during a read
    assign nxt_event = ((clear ? EVENT_RESET : event_ff) | rise | direct_set) & EVENT_MASK;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cond_ff <= COND_RESET;
            history_ff <= HISTORY_RESET;
            armed_ff <= 1'b0;
            event_ff <= EVENT_RESET;
        end else begin
            cond_ff <= cond_in & COND_MASK; // [RQ10] [RQ26]
            history_ff <= nxt_history;
            armed_ff <= 1'b1;
            event_ff <= nxt_event; // [RQ1] [RQ27]
        end
    end

endmodule // edge_event_latch

`default_nettype wire

/* tb/smu_status_monitor.sv */
// Assertion checker for the status event block
`timescale 1ns/10ps
`default_nettype none

module smu_status_monitor
    import smu_status_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [REG_W-1:0] cmd_wdata,
    input wire logic cmd_ready_ff,
    input wire logic rsp_valid_ff,
    input wire logic [REG_W-1:0] rsp_data_ff,
    input wire logic measure_summary_ff,
    input wire logic [REG_W-1:0] measure_enable_ff,
    input wire logic interlock_active,
    input wire logic ch1_upper_limiting,
    input wire logic ch1_emergency,
    input wire logic ch1_sweep_running,
    input wire logic ch1_measuring,
    input wire logic storage_busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic take = cmd_valid && cmd_ready_ff;
    sequence s_reply;
        rsp_valid_ff && !cmd_ready_ff ##1 !rsp_valid_ff && cmd_ready_ff;
    endsequence
    property p_reply;
        take |=> s_reply;
    endproperty
    a_reply: assert property (p_reply) else $error("reply not one cycle");
    property p_silent;
        !take |=> !rsp_valid_ff;
    endproperty
    a_silent: assert property (p_silent) else $error("reply without command");
    property p_src_res;
        take && cmd_code <= 3'h1 |=> (rsp_data_ff & ~SRC_EVENT_MASK) == 16'h0000;
    endproperty
    a_src_res: assert property (p_src_res) else $error("source unused bit set");
    property p_mea_res;
        take && cmd_code inside {3'h2, 3'h3} |=> (rsp_data_ff & ~MEA_MASK) == 16'h0000;
    endproperty
    a_mea_res: assert property (p_mea_res) else $error("measure unused bit set");
    property p_trip;
        take && cmd_code == 3'h0 |=> !rsp_data_ff[12] && !rsp_data_ff[4];
    endproperty
    a_trip: assert property (p_trip) else $error("trip bit in condition");
    // Inputs land in the condition word one edge before the read is taken
    property p_src_cond;
        take && cmd_code == 3'h0 && $past(rst_n) |=>
            rsp_data_ff[14] == $past(interlock_active, 2) &&
            rsp_data_ff[3] == $past(ch1_upper_limiting, 2) &&
            rsp_data_ff[5] == $past(ch1_emergency, 2) &&
            rsp_data_ff[1] == !$past(ch1_sweep_running, 2);
    endproperty
    a_src_cond: assert property (p_src_cond) else $error("source condition");
    property p_mea_cond;
        take && cmd_code == 3'h2 && $past(rst_n) |=>
            rsp_data_ff[0] == !$past(ch1_measuring, 2) &&
            rsp_data_ff[14] == !$past(storage_busy, 2);
    endproperty
    a_mea_cond: assert property (p_mea_cond) else $error("measure condition");
    property p_men;
        take && cmd_code == 3'h5 |=> measure_enable_ff == ($past(cmd_wdata) & MEA_MASK);
    endproperty
    a_men: assert property (p_men) else $error("measure enable write");
    property p_mask;
        $past(measure_enable_ff) == 16'h0000 |-> !measure_summary_ff;
    endproperty
    a_mask: assert property (p_mask) else $error("masked summary set");
endmodule // smu_status_monitor

bind source_measure_event_status smu_status_monitor mon (
    .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_ready_ff(cmd_ready_ff), .rsp_valid_ff(rsp_valid_ff),
    .rsp_data_ff(rsp_data_ff), .measure_summary_ff(measure_summary_ff),
    .measure_enable_ff(measure_enable_ff), .interlock_active(interlock_active),
    .ch1_upper_limiting(ch1_upper_limiting), .ch1_emergency(ch1_emergency),
    .ch1_sweep_running(ch1_sweep_running), .ch1_measuring(ch1_measuring),
    .storage_busy(storage_busy)
);

`default_nettype wire

/* tb/status_controller_model.sv */
// Remote controller model issuing status commands
`timescale 1ns/10ps
`default_nettype none

module status_controller_model
    import smu_status_pkg::*;
(
    input wire logic clock,
    input wire logic cmd_ready_ff,
    input wire logic rsp_valid_ff,
    input wire logic [REG_W-1:0] rsp_data_ff,
    output logic cmd_valid,
    output logic [2:0] cmd_code,
    output logic [REG_W-1:0] cmd_wdata
);
    int slow = 0;
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 3'h0;
        cmd_wdata = 16'h0000;
    end
    // Event queries clear the register, so each is sent once
    task automatic issue(input logic [2:0] code, input logic [REG_W-1:0] wd,
                         output logic [REG_W-1:0] rd, output logic ok);
        int n;
        n = 0;
        repeat (slow) @(negedge clock);
        @(negedge clock);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_wdata <= wd;
        while (cmd_ready_ff !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        ok = (n < 20) && (rsp_valid_ff === 1'b1);
        rd = rsp_data_ff;
        // Released lines must not look like a held request
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
        cmd_wdata <= ~wd;
    endtask
endmodule // status_controller_model

`default_nettype wire

/* tb/source_measure_event_status_bench.sv */
// Self-checking bench for the status event block
`timescale 1ns/10ps
`default_nettype none

module source_measure_event_status_bench;
    import smu_status_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] s = 16'h0000;
    logic [15:0] m = 16'h0000;
    logic st1 = 1'b0, st2 = 1'b0, run1 = 1'b0, run2 = 1'b0;
    logic trig = 1'b0, busy = 1'b0, mea1 = 1'b0, mea2 = 1'b0;
    logic cv, rdy, rv, ssum, msum;
    logic [2:0] cc;
    logic [15:0] cw, rd, men;
    int n_mismatch = 0;
    int n_tests = 0;

    always #5 clock = ~clock;

    source_measure_event_status uut (
        .clock(clock), .rst_n(rst_n), .ch1_sweep_start(st1), .ch1_sweep_running(run1),
        .ch1_emergency(s[5]), .ch1_output_tripped(s[4]), .ch1_upper_limiting(s[3]),
        .ch1_lower_limiting(s[2]), .ch2_sweep_start(st2), .ch2_sweep_running(run2),
        .ch2_emergency(s[13]), .ch2_output_tripped(s[12]), .ch2_upper_limiting(s[11]),
        .ch2_lower_limiting(s[10]), .interlock_active(s[14]), .measure_trigger(trig),
        .storage_busy(busy), .ch1_measuring(mea1), .ch1_over_range(m[5]),
        .ch1_compare_above(m[3]), .ch1_compare_below(m[2]), .ch2_measuring(mea2),
        .ch2_over_range(m[13]), .ch2_compare_above(m[11]), .ch2_compare_below(m[10]),
        .cmd_valid(cv), .cmd_code(cc), .cmd_wdata(cw), .cmd_ready_ff(rdy),
        .rsp_valid_ff(rv), .rsp_data_ff(rd), .source_summary_ff(ssum),
        .measure_summary_ff(msum), .measure_enable_ff(men)
    );

    status_controller_model ctl (
        .clock(clock), .cmd_ready_ff(rdy), .rsp_valid_ff(rv), .rsp_data_ff(rd),
        .cmd_valid(cv), .cmd_code(cc), .cmd_wdata(cw)
    );

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmd(input logic [2:0] c, input logic [15:0] w, input logic [15:0] e,
                       input string nm);
        logic [15:0] r;
        logic ok;
        ctl.issue(c, w, r, ok);
        chk({nm, " reply"}, 16'h0001, {15'h0, ok});
        if (ok !== 1'b1) end_of_test();
        chk(nm, e, r);
    endtask

    task automatic t_levels;
        @(negedge clock);
        s = 16'h7C3C;
        m = 16'h2C2C;
        @(negedge clock);
        s = 16'h6C2C;
        repeat (3) @(negedge clock);
        cmd(3'h0, 16'h0000, 16'h6E2E, "src cond");
        cmd(3'h0, 16'h0000, 16'h6E2E, "src cond again");
        cmd(3'h2, 16'h0000, 16'h6D2D, "mea cond");
        cmd(3'h1, 16'h0000, 16'h7C3C, "src event");
        cmd(3'h1, 16'h0000, 16'h0000, "src event after read");
        cmd(3'h7, 16'h0000, 16'h0000, "clear status");
        cmd(3'h3, 16'h0000, 16'h0000, "mea event after clear");
        s = 16'h0000;
        m = 16'h0000;
    endtask

    task automatic t_sweep;
        @(negedge clock);
        {st1, st2, run1, run2} = 4'hF;
        @(negedge clock);
        {st1, st2} = 2'h0;
        cmd(3'h0, 16'h0000, 16'h0000, "src cond sweeping");
        // Overlapping start and trigger last a single cycle
        {st1, st2, trig, busy, mea1, mea2} = 6'h3F;
        @(negedge clock);
        {st1, st2, trig} = 3'h0;
        @(negedge clock);
        {run1, run2, busy, mea1, mea2} = 5'h00;
        repeat (3) @(negedge clock);
        ctl.slow = 2;
        cmd(3'h0, 16'h0000, 16'h0303, "src cond done");
        cmd(3'h2, 16'h0000, 16'h4101, "mea cond idle");
        chk("src sum masked", 16'h0000, {15'h0, ssum});
        cmd(3'h4, 16'h0040, 16'h0000, "src en unused");
        @(negedge clock);
        chk("src sum unused", 16'h0000, {15'h0, ssum});
        // Unused enable bits are dropped on write
        cmd(3'h6, 16'h0000, 16'h0000, "src en read");
        cmd(3'h4, 16'h0001, 16'h0000, "src en done");
        @(negedge clock);
        chk("src sum", 16'h0001, {15'h0, ssum});
        cmd(3'h5, 16'h0100, 16'h0000, "mea en");
        @(negedge clock);
        chk("mea en", 16'h0100, men);
        chk("mea sum", 16'h0001, {15'h0, msum});
        ctl.slow = 0;
        cmd(3'h1, 16'h0000, 16'h8303, "src event sweep");
        cmd(3'h3, 16'h0000, 16'hC101, "mea event sweep");
        @(negedge clock);
        chk("src sum cleared", 16'h0000, {15'h0, ssum});
        chk("mea sum cleared", 16'h0000, {15'h0, msum});
        cmd(3'h3, 16'h0000, 16'h0000, "mea event after read");
    endtask

    task automatic t_clear;
        @(negedge clock);
        s = 16'h4000;
        repeat (2) @(negedge clock);
        cmd(3'h7, 16'h0000, 16'h0000, "clear status src");
        // Edge reaches the event word on the edge that takes the read
        s = 16'h4008;
        cmd(3'h1, 16'h0000, 16'h0000, "src event after clear");
        cmd(3'h1, 16'h0000, 16'h0008, "src event kept");
        s = 16'h0000;
    endtask

    initial begin
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        t_levels();
        t_sweep();
        t_clear();
        end_of_test();
    end

    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        $display("MISMATCH run time expected end seen hang");
        end_of_test();
    end
endmodule // source_measure_event_status_bench

`default_nettype wire
